// file: hdl/cmpc_pkg.sv
package cmpc_pkg;

   // Register map (index on the plain register port)
   localparam int          ADDR_W         = 3;
   localparam logic [2:0]  OFS_CTRL0      = 3'h0;
   localparam logic [2:0]  OFS_CTRL1      = 3'h1;
   localparam logic [2:0]  OFS_FLAGS      = 3'h2;
   localparam logic [2:0]  OFS_ENABLES    = 3'h3;

   // Control register 0 fields
   localparam int          C0_ON          = 7;
   localparam int          C0_RESULT      = 6;
   localparam int          C0_PIN_OE      = 5;
   localparam int          C0_INVERT      = 4;
   localparam int          C0_REF_SEL     = 2;
   localparam int          C0_NEG_SEL     = 0;
   localparam logic [7:0]  C0_WR_MASK     = 8'hB5;
   localparam logic [7:0]  C0_RESET       = 8'h00;

   // Control register 1 fields
   localparam int          C1_ALT_CLK     = 4;
   localparam int          C1_HYST        = 3;
   localparam int          C1_GATE_SRC    = 1;
   localparam int          C1_SYNC        = 0;
   localparam logic [7:0]  C1_WR_MASK     = 8'h1B;
   localparam logic [7:0]  C1_RESET       = 8'h02;

   // Flag and enable register fields
   localparam int          FL_CHANGE      = 0;
   localparam int          EN_CHANGE      = 0;
   localparam int          EN_PERIPH      = 1;
   localparam int          EN_GLOBAL      = 2;
   localparam logic [7:0]  EN_WR_MASK     = 8'h07;
   localparam logic [7:0]  EN_RESET       = 8'h00;

   // Instruction cycle: four clocks, phase one first
   localparam int          PHASES_PER_CYCLE = 4;
   localparam logic [1:0]  PH_ONE         = 2'h0;
   localparam logic [1:0]  PH_LAST        = 2'h3;

   // Bias settling time software waits after enabling
   localparam int          SETTLE_NS      = 1000;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          SETTLE_CYCLES  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : cmpc_pkg

// file: hdl/cmpc_top.sv
`timescale 1ns/1ps
module cmpc_top
#(
   parameter int PHASES = cmpc_pkg::PHASES_PER_CYCLE
)
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       clk_en,
   input  wire logic [cmpc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [7:0]                 reg_rdata,
   input  wire logic                       raw_compare,
   input  wire logic                       pin_direction,
   input  wire logic                       port_data_latch,
   input  wire logic                       timer_clk_post,
   input  wire logic                       timer_gate_pin,
   input  wire logic                       timer_on,
   input  wire logic                       timer_gate_enable,
   input  wire logic                       sleeping,
   output logic                            comparator_on,
   output logic                            reference_select,
   output logic                            negative_channel_select,
   output logic                            hysteresis_enable,
   output logic                            timer_alt_clock,
   output logic                            pin_out,
   output logic                            pin_oe,
   output logic                            timer_count_enable,
   output logic                            irq_request,
   output logic                            wake_request
);

   // Elaboration check: the phase counter is two bits wide
   if (PHASES != cmpc_pkg::PHASES_PER_CYCLE)
   begin : g_bad_phases
      $error("cmpc_top: PHASES must equal four");
   end

   typedef struct packed {
      logic [1:0] phase;
      logic [1:0] cmp_sync;
      logic [2:0] tclk_sync;
      logic [1:0] gate_sync;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] enables;
      logic       compare_result_cycle;
      logic       mm_first;
      logic       mm_prev;
      logic       change_flag;
      logic       sync_latch;
      logic [7:0] rdata;
      logic       on;
      logic       ref_sel;
      logic       neg_sel;
      logic       hyst;
      logic       alt_clk;
      logic       pin_val;
      logic       pin_drv;
      logic       count_en;
      logic       irq;
      logic       wake;
   } cmpc_state_t;

   cmpc_state_t st_r;
   cmpc_state_t st_nxt;
   logic [1:0]  rst_sync_r;
   logic        rst_n;

   // Field of a register by bit position
   function automatic logic bit_of(input logic [7:0] v, input int pos);
      bit_of = v[pos];
   endfunction

   // Register data with only writable bits updated
   function automatic logic [7:0] masked_write(input logic [7:0] old,
                                               input logic [7:0] wd,
                                               input logic [7:0] msk);
      masked_write = (old & ~msk) | (wd & msk);
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_sync_r <= 2'h0;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   logic       cmp_in;
   logic       compare_result_live;
   logic       mismatch;
   logic       rd_ctrl0;
   logic       wr_ctrl0;
   logic       tclk_fall;
   logic       gate_level;
   logic       gate_sel;
   logic [7:0] ctrl0_view;

   always_comb
   begin
      st_nxt = st_r;

      // Synchronise pins and the timer clock
      st_nxt.cmp_sync  = {st_r.cmp_sync[0], raw_compare};
      st_nxt.tclk_sync = {st_r.tclk_sync[1:0], timer_clk_post};
      st_nxt.gate_sync = {st_r.gate_sync[0], timer_gate_pin};
      cmp_in           = st_r.cmp_sync[1];

      // Polarity; a disabled comparator reads low
      compare_result_live = bit_of(st_r.ctrl0, cmpc_pkg::C0_ON) &
                  (cmp_in ^ bit_of(st_r.ctrl0, cmpc_pkg::C0_INVERT));

      // Instruction cycle phases
      st_nxt.phase = (st_r.phase == cmpc_pkg::PH_LAST) ? cmpc_pkg::PH_ONE
                                                        : st_r.phase + 2'h1;

      // Second mismatch latch, also the registered internal result
      if (st_r.phase == cmpc_pkg::PH_ONE)
      begin
         st_nxt.compare_result_cycle = compare_result_live;
      end

      rd_ctrl0 = reg_rd && (reg_addr == cmpc_pkg::OFS_CTRL0);
      wr_ctrl0 = reg_wr && (reg_addr == cmpc_pkg::OFS_CTRL0);

      // A write begins with a read, so both reload the first latch;
      // a change landing in that same cycle is absorbed and not flagged
      if (rd_ctrl0 || wr_ctrl0)
      begin
         st_nxt.mm_first = st_r.compare_result_cycle;
      end

      mismatch = (st_r.mm_first ^ st_r.compare_result_cycle) & ~(rd_ctrl0 | wr_ctrl0);
      st_nxt.mm_prev = mismatch;

      // Control 0 as software sees it
      ctrl0_view = st_r.ctrl0;
      ctrl0_view[cmpc_pkg::C0_RESULT] = st_r.compare_result_cycle;

      // Register writes
      if (wr_ctrl0)
      begin
         st_nxt.ctrl0 = masked_write(st_r.ctrl0, reg_wdata, cmpc_pkg::C0_WR_MASK);
      end
      if (reg_wr && (reg_addr == cmpc_pkg::OFS_CTRL1))
      begin
         st_nxt.ctrl1 = masked_write(st_r.ctrl1, reg_wdata, cmpc_pkg::C1_WR_MASK);
      end
      if (reg_wr && (reg_addr == cmpc_pkg::OFS_ENABLES))
      begin
         st_nxt.enables = masked_write(st_r.enables, reg_wdata, cmpc_pkg::EN_WR_MASK);
      end
      if (reg_wr && (reg_addr == cmpc_pkg::OFS_FLAGS))
      begin
         st_nxt.change_flag = reg_wdata[cmpc_pkg::FL_CHANGE];
      end

      // Edge of mismatch sets the flag; set beats a clearing write
      if (mismatch && !st_r.mm_prev)
      begin
         st_nxt.change_flag = 1'b1;
      end

      // Read data, one cycle after the strobe; unmapped reads zero
      st_nxt.rdata = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            cmpc_pkg::OFS_CTRL0:   st_nxt.rdata = ctrl0_view;
            cmpc_pkg::OFS_CTRL1:   st_nxt.rdata = st_r.ctrl1;
            cmpc_pkg::OFS_FLAGS:   st_nxt.rdata[cmpc_pkg::FL_CHANGE] = st_r.change_flag;
            cmpc_pkg::OFS_ENABLES: st_nxt.rdata = st_r.enables;
            default:               st_nxt.rdata = 8'h00;
         endcase
      end

      // Timer-clock falling edge latch
      tclk_fall = st_r.tclk_sync[2] & ~st_r.tclk_sync[1];
      if (tclk_fall)
      begin
         st_nxt.sync_latch = compare_result_live;
      end

      gate_level = bit_of(st_r.ctrl1, cmpc_pkg::C1_SYNC) ? st_r.sync_latch
                                                          : compare_result_live;
      gate_sel   = bit_of(st_r.ctrl1, cmpc_pkg::C1_GATE_SRC) ? st_r.gate_sync[1]
                                                              : gate_level;
      st_nxt.count_en = timer_on & (~timer_gate_enable | gate_sel);

      // Analog steering
      st_nxt.on      = bit_of(st_nxt.ctrl0, cmpc_pkg::C0_ON);
      st_nxt.ref_sel = bit_of(st_nxt.ctrl0, cmpc_pkg::C0_REF_SEL);
      st_nxt.neg_sel = bit_of(st_nxt.ctrl0, cmpc_pkg::C0_NEG_SEL);
      st_nxt.hyst    = bit_of(st_nxt.ctrl1, cmpc_pkg::C1_HYST);
      st_nxt.alt_clk = bit_of(st_nxt.ctrl1, cmpc_pkg::C1_ALT_CLK);

      // Pin: comparator overrides port latch; the path has no cycle latch
      st_nxt.pin_val = bit_of(st_r.ctrl0, cmpc_pkg::C0_PIN_OE) ? gate_level
                                                              : port_data_latch;
      st_nxt.pin_drv = ~pin_direction;

      // Interrupt and wake
      st_nxt.irq  = st_nxt.change_flag &
                    bit_of(st_nxt.enables, cmpc_pkg::EN_CHANGE) &
                    bit_of(st_nxt.enables, cmpc_pkg::EN_PERIPH) &
                    bit_of(st_nxt.enables, cmpc_pkg::EN_GLOBAL);
      st_nxt.wake = st_nxt.change_flag & sleeping &
                    bit_of(st_nxt.enables, cmpc_pkg::EN_CHANGE) &
                    bit_of(st_nxt.enables, cmpc_pkg::EN_PERIPH);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r         <= '0;
         st_r.ctrl0   <= cmpc_pkg::C0_RESET;
         st_r.ctrl1   <= cmpc_pkg::C1_RESET;
         st_r.enables <= cmpc_pkg::EN_RESET;
      end
      else if (clk_en)
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata               = st_r.rdata;
   assign comparator_on           = st_r.on;
   assign reference_select        = st_r.ref_sel;
   assign negative_channel_select = st_r.neg_sel;
   assign hysteresis_enable       = st_r.hyst;
   assign timer_alt_clock         = st_r.alt_clk;
   assign pin_out                 = st_r.pin_val;
   assign pin_oe                  = st_r.pin_drv;
   assign timer_count_enable      = st_r.count_en;
   assign irq_request             = st_r.irq;
   assign wake_request            = st_r.wake;

endmodule // cmpc_top

// file: sim/cmpc_analog_model.sv
`timescale 1ns/1ps
module cmpc_analog_model (
   input  wire logic       level,
   input  wire logic [7:0] resp_ns,
   output logic            raw_compare
);
   // Raw compare bit follows the commanded level after a settable response time
   initial raw_compare = 1'b0;
   always @(level)
      raw_compare <= #(resp_ns) level;
endmodule // cmpc_analog_model

// file: sim/cmpc_asserts.sv
`timescale 1ns/1ps
module cmpc_asserts (
   input wire logic                         clk,
   input wire logic                         resetn,
   input wire logic [cmpc_pkg::ADDR_W-1:0]  reg_addr,
   input wire logic [7:0]                   reg_wdata,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_rdata,
   input wire logic                         pin_direction,
   input wire logic                         sleeping,
   input wire logic                         comparator_on,
   input wire logic                         reference_select,
   input wire logic                         pin_oe,
   input wire logic                         wake_request
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence wr_ctrl0;
      reg_wr && reg_addr == cmpc_pkg::OFS_CTRL0;
   endsequence
   sequence rd_ctrl0;
      reg_rd && reg_addr == cmpc_pkg::OFS_CTRL0;
   endsequence
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_ctrl0_zeros: assert property (rd_ctrl0 |=> !reg_rdata[3] && !reg_rdata[1])
      else $error("control 0 unused bits not zero");
   a_unmapped_zero: assert property (reg_rd && reg_addr[2] |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_on_set: assert property (wr_ctrl0 ##0 reg_wdata[7] |-> ##[1:2] comparator_on)
      else $error("comparator on not set by write");
   a_on_clear: assert property (wr_ctrl0 ##0 !reg_wdata[7] |-> ##[1:2] !comparator_on)
      else $error("comparator on not cleared by write");
   a_ref_follow: assert property (wr_ctrl0 ##0 !reg_wdata[2] |-> ##[1:2] !reference_select)
      else $error("reference select not cleared");
   a_pin_drive: assert property (pin_oe |-> $past(pin_direction) == 1'b0)
      else $error("pin driven while direction is input");
   a_wake_sleep: assert property (wake_request |-> $past(sleeping))
      else $error("wake request while awake");
endmodule // cmpc_asserts

bind cmpc_top cmpc_asserts cmpc_asserts_i (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .pin_direction, .sleeping, .comparator_on, .reference_select,
   .pin_oe, .wake_request);

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
   logic       clk, resetn, clk_en, reg_wr, reg_rd, sleeping, cmd, res;
   logic       pin_direction, port_data_latch, timer_on, timer_gate_enable;
   logic       tclk, gpin;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, resp_ns, d;
   logic       raw_compare, comparator_on, reference_select, negative_channel_select;
   logic       hysteresis_enable, timer_alt_clock, pin_out, pin_oe;
   logic       timer_count_enable, irq_request, wake_request;
   int         n_errors = 0;
   int         compares = 0;
   int         seed = 86;

   cmpc_analog_model cmpc_analog_model_i (.level(cmd), .resp_ns, .raw_compare);
   cmpc_top cmpc_top_i (
      .clk, .resetn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .raw_compare, .pin_direction, .port_data_latch, .timer_clk_post(tclk),
      .timer_gate_pin(gpin), .timer_on, .timer_gate_enable, .sleeping, .comparator_on,
      .reference_select, .negative_channel_select, .hysteresis_enable, .timer_alt_clock,
      .pin_out, .pin_oe, .timer_count_enable, .irq_request, .wake_request);

   function automatic logic [7:0] exp_c0(input logic [7:0] v, input logic r);
      exp_c0 = (v & cmpc_pkg::C0_WR_MASK) | {1'b0, v[7] & (r ^ v[4]), 6'h00};
   endfunction

   task automatic report_and_stop;
      if (n_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask

   // Turn the analog input round and give the change time to reach the flag
   task automatic flip;
      cmd <= ~cmd;
      settle(30);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #200000;
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      {resetn, reg_wr, reg_rd, sleeping, cmd, pin_direction} = 6'h00;
      {port_data_latch, timer_on, timer_gate_enable} = 3'h0;
      clk_en = 1'b1;
      tclk = 1'b0;
      gpin = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      resp_ns = 8'h01;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a < 8; a++)
         rd(a[2:0], (a == 1) ? cmpc_pkg::C1_RESET : 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         d = 8'($random(seed));
         resp_ns <= i[0] ? 8'h96 : 8'h01;
         cmd <= d[6];
         pin_direction <= d[3];
         port_data_latch <= d[1];
         wr(cmpc_pkg::OFS_CTRL0, d);
         settle(30);
         res = d[7] & (d[6] ^ d[4]);
         rd(cmpc_pkg::OFS_CTRL0, exp_c0(d, d[6]));
         chk({5'h00, comparator_on, reference_select, negative_channel_select},
             {5'h00, d[7], d[2], d[0]});
         chk({6'h00, pin_oe, pin_out}, {6'h00, ~d[3], d[5] ? res : d[1]});
      end
      resp_ns <= 8'h01;
      wr(cmpc_pkg::OFS_CTRL0, 8'h80);
      settle(cmpc_pkg::SETTLE_CYCLES);
      rd(cmpc_pkg::OFS_CTRL0, {1'b1, cmd, 6'h00});
      wr(cmpc_pkg::OFS_FLAGS, 8'h00);
      wr(cmpc_pkg::OFS_ENABLES, 8'h07);
      flip();
      chk({7'h00, irq_request}, 8'h01);
      wr(cmpc_pkg::OFS_FLAGS, 8'h00);
      flip();
      rd(cmpc_pkg::OFS_FLAGS, 8'h00);
      flip();
      wr(cmpc_pkg::OFS_CTRL0, 8'h80);
      wr(cmpc_pkg::OFS_FLAGS, 8'h00);
      flip();
      rd(cmpc_pkg::OFS_FLAGS, 8'h01);
      wr(cmpc_pkg::OFS_ENABLES, 8'h03);
      sleeping <= 1'b1;
      settle(4);
      chk({6'h00, irq_request, wake_request}, 8'h01);
      sleeping <= 1'b0;
      wr(cmpc_pkg::OFS_FLAGS, 8'h00);
      wr(cmpc_pkg::OFS_FLAGS, 8'h01);
      rd(cmpc_pkg::OFS_FLAGS, 8'h01);
      wr(cmpc_pkg::OFS_CTRL1, 8'hFF);
      rd(cmpc_pkg::OFS_CTRL1, cmpc_pkg::C1_WR_MASK);
      chk({6'h00, hysteresis_enable, timer_alt_clock}, 8'h03);
      wr(cmpc_pkg::OFS_CTRL1, 8'h00);
      timer_on <= 1'b1;
      timer_gate_enable <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         flip();
         chk({7'h00, timer_count_enable}, {7'h00, cmd});
      end
      // Synchronised gate only follows the result at a timer-clock falling edge
      wr(cmpc_pkg::OFS_CTRL1, 8'h01);
      tclk <= 1'b1;
      settle(8);
      tclk <= 1'b0;
      settle(8);
      chk({7'h00, timer_count_enable}, {7'h00, cmd});
      tclk <= 1'b1;
      flip();
      chk({7'h00, timer_count_enable}, {7'h00, ~cmd});
      tclk <= 1'b0;
      settle(8);
      chk({7'h00, timer_count_enable}, {7'h00, cmd});
      // Gate source from the external gate pin
      wr(cmpc_pkg::OFS_CTRL1, 8'h02);
      gpin <= 1'b1;
      settle(6);
      chk({7'h00, timer_count_enable}, 8'h01);
      gpin <= 1'b0;
      settle(6);
      chk({7'h00, timer_count_enable}, 8'h00);
      resetn <= 1'b0;
      settle(3);
      resetn <= 1'b1;
      settle(3);
      rd(cmpc_pkg::OFS_CTRL1, cmpc_pkg::C1_RESET);
      rd(cmpc_pkg::OFS_CTRL0, 8'h00);
      report_and_stop();
   end
endmodule // tb
